// ---- hdl/vsd_regs.svh ----
// register offsets, field positions, reset values and codes of the segment decoder
// assumes a 32-bit axi4-lite slave with 12-bit byte addresses
`ifndef VSD_REGS_SVH
`define VSD_REGS_SVH
`define VSD_OFF_STATUS 12'h000
`define VSD_OFF_ENTRY_HI 12'h004
`define VSD_OFF_CONFIG 12'h008
`define VSD_OFF_MODE 12'h00c
`define VSD_OFF_RESULT 12'h010
`define VSD_PRIV_HI 4
`define VSD_PRIV_LO 3
`define VSD_ERR_LVL_BIT 2
`define VSD_EXC_LVL_BIT 1
`define VSD_PRIV_KERN 2'h0
`define VSD_PRIV_SUP 2'h1
`define VSD_PRIV_USER 2'h2
`define VSD_STATUS_RST 5'h00
`define VSD_SEG0_ATTR_RST 3'h2
`define VSD_C_CACHED 3'h3
`define VSD_C_UNCACHED 3'h2
`define VSD_TOP_LOW 2'h0
`define VSD_TOP_SUP 2'h1
`define VSD_TOP_PHYS 2'h2
`define VSD_TOP_HIGH 2'h3
`define VSD_CSEL_SEG0 2'h0
`define VSD_CSEL_SEG1 2'h1
`define VSD_CSEL_SUP 2'h2
`define VSD_CSEL_KERN 2'h3
`define VSD_REFILL_OFF 12'h080
`define VSD_RESP_OKAY 2'h0
`define VSD_RESP_SLVERR 2'h2
`endif

// ---- hdl/vsd_pkg.sv ----
// types shared by the segment decoder modules
// assumes the offsets and codes of vsd_regs.svh
package vsd_pkg;
  typedef enum logic [1:0] {mode_kern, mode_sup, mode_user} vsd_mode_t;
  typedef enum logic [3:0] {
    seg_none, seg_user64, seg_sup_user, seg_sup_cur, seg_sup_compat,
    seg_kern_user, seg_kern_sup, seg_kern_phys, seg_kern_mapped,
    seg_compat0, seg_compat1, seg_compat_sup, seg_compat3
  } vsd_seg_t;
endpackage

// ---- hdl/vsd_dec_if.sv ----
// signals between the decoder core and the top of the segment decoder
// assumes one clock; va and the decoder outputs are combinational, priv, exc_lvl, err_lvl and seg0_attr come from registers
`timescale 1ns/1ps
interface vsd_dec_if;
  logic [63:0] va;
  logic [1:0] priv;
  logic exc_lvl;
  logic err_lvl;
  logic [2:0] seg0_attr;
  vsd_pkg::vsd_mode_t mode;
  vsd_pkg::vsd_seg_t seg;
  logic mapped;
  logic addr_err;
  logic [47:0] pa;
  logic [2:0] attr;
  logic cached;
  modport dec (input va, priv, exc_lvl, err_lvl, seg0_attr,
    output mode, seg, mapped, addr_err, pa, attr, cached);
  modport user (output va, priv, exc_lvl, err_lvl, seg0_attr,
    input mode, seg, mapped, addr_err, pa, attr, cached);
endinterface

// ---- hdl/vsd_seg_decode.sv ----
// combinational mode and address segment decode
// assumes the mode inputs are stable register outputs of the top module and va is the live request address
`timescale 1ns/1ps
`include "vsd_regs.svh"
module vsd_seg_decode (
  vsd_dec_if.dec dif
);
  logic [1:0] top;
  logic [1:0] csel;
  logic hi_zero;
  logic compat;
  assign top = dif.va[63:62];
  assign csel = dif.va[30:29];
  assign hi_zero = (dif.va[61:48] == 14'h0000);
  assign compat = (dif.va[61:31] == 31'h7fffffff);
  always_comb begin
    if (dif.exc_lvl || dif.err_lvl || dif.priv == `VSD_PRIV_KERN) begin
      dif.mode = vsd_pkg::mode_kern;
    end else if (dif.priv == `VSD_PRIV_SUP) begin
      dif.mode = vsd_pkg::mode_sup;
    end else begin
      dif.mode = vsd_pkg::mode_user;
    end
  end
  always_comb begin
    dif.seg = vsd_pkg::seg_none;
    dif.pa = 48'h000000000000;
    dif.attr = `VSD_C_UNCACHED;
    unique case (dif.mode)
      vsd_pkg::mode_user: begin
        if (top == `VSD_TOP_LOW && hi_zero) dif.seg = vsd_pkg::seg_user64;
      end
      vsd_pkg::mode_sup: begin
        if (top == `VSD_TOP_LOW && hi_zero) dif.seg = vsd_pkg::seg_sup_user;
        else if (top == `VSD_TOP_SUP && hi_zero) dif.seg = vsd_pkg::seg_sup_cur;
        else if (top == `VSD_TOP_HIGH && compat && csel == `VSD_CSEL_SUP) dif.seg = vsd_pkg::seg_sup_compat;
      end
      vsd_pkg::mode_kern: begin
        unique case (top)
          `VSD_TOP_LOW: if (hi_zero) dif.seg = vsd_pkg::seg_kern_user;
          `VSD_TOP_SUP: if (hi_zero) dif.seg = vsd_pkg::seg_kern_sup;
          `VSD_TOP_PHYS: begin
            if (dif.va[58:48] == 11'h000) dif.seg = vsd_pkg::seg_kern_phys;
            dif.pa = dif.va[47:0];
            dif.attr = dif.va[61:59];
          end
          `VSD_TOP_HIGH: begin
            if (!compat) begin
              dif.seg = vsd_pkg::seg_kern_mapped;
            end else begin
              dif.pa = {19'h00000, dif.va[28:0]};
              unique case (csel)
                `VSD_CSEL_SEG0: begin
                  dif.seg = vsd_pkg::seg_compat0;
                  dif.attr = dif.seg0_attr;
                end
                `VSD_CSEL_SEG1: dif.seg = vsd_pkg::seg_compat1;
                `VSD_CSEL_SUP: dif.seg = vsd_pkg::seg_compat_sup;
                `VSD_CSEL_KERN: dif.seg = vsd_pkg::seg_compat3;
              endcase
            end
          end
        endcase
      end
    endcase
  end
  assign dif.addr_err = (dif.seg == vsd_pkg::seg_none);
  assign dif.mapped = !(dif.seg inside {vsd_pkg::seg_none, vsd_pkg::seg_kern_phys,
    vsd_pkg::seg_compat0, vsd_pkg::seg_compat1});
  assign dif.cached = !dif.mapped && !dif.addr_err && (dif.attr == `VSD_C_CACHED);
endmodule

// ---- hdl/vsd_top.sv ----
// virtual address segment and privilege mode decoder with axi4-lite registers
// assumes one 250 mhz clock, synchronous active-high reset, pipeline inputs synchronous
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "vsd_regs.svh"
module vsd_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [11:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [11:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_req,
  input wire logic [63:0] i_va,
  input wire logic i_page_16m,
  input wire logic i_exc_take,
  input wire logic i_exc_return,
  input wire logic i_tlb_miss,
  input wire logic i_tlb_global,
  output logic o_valid,
  output logic [1:0] o_mode,
  output logic [3:0] o_seg,
  output logic o_mapped,
  output logic o_tag_append,
  output logic o_addr_err,
  output logic [47:0] o_pa,
  output logic [2:0] o_attr,
  output logic o_cached,
  output logic [7:0] o_asid,
  output logic o_global,
  output logic [23:0] o_page_offset,
  output logic [35:0] o_vpn,
  output logic o_refill_ext,
  output logic [11:0] o_refill_offset
);
  vsd_dec_if dif ();
  logic [1:0] priv_reg;
  logic exc_lvl_reg;
  logic err_lvl_reg;
  logic [7:0] asid_reg;
  logic [2:0] seg0_attr_reg;
  logic [63:0] va_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic aw_hold_next;
  logic w_hold_next;
  logic rvalid_next;
  logic sw_status;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  localparam logic [4:0] status_rst = `VSD_STATUS_RST;

  function automatic logic known_off(input logic [11:0] off);
    known_off = off inside {`VSD_OFF_STATUS, `VSD_OFF_ENTRY_HI, `VSD_OFF_CONFIG,
      `VSD_OFF_MODE, `VSD_OFF_RESULT};
  endfunction

  // decoder works on the registered mode bits and the live request address
  assign dif.va = i_va;
  assign dif.priv = priv_reg;
  assign dif.exc_lvl = exc_lvl_reg;
  assign dif.err_lvl = err_lvl_reg;
  assign dif.seg0_attr = seg0_attr_reg;
  vsd_seg_decode u_dec (
    .dif(dif)
  );

  // write channel handshake
  assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
  assign w_take = i_s_axi_wvalid && o_s_axi_wready;
  assign do_write = aw_hold_reg && w_hold_reg && !o_s_axi_bvalid;
  assign aw_hold_next = do_write ? 1'b0 : (aw_hold_reg || aw_take);
  assign w_hold_next = do_write ? 1'b0 : (w_hold_reg || w_take);
  assign sw_status = do_write && awaddr_reg == `VSD_OFF_STATUS && wstrb_reg[0];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      o_s_axi_awready <= !aw_hold_next;
      o_s_axi_wready <= !w_hold_next;
      if (aw_take) awaddr_reg <= {i_s_axi_awaddr[11:2], 2'h0};
      if (w_take) begin
        wdata_reg <= i_s_axi_wdata;
        wstrb_reg <= i_s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `VSD_RESP_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= known_off(awaddr_reg) ? `VSD_RESP_OKAY : `VSD_RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // mode bits: hardware events win over a software write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      priv_reg <= status_rst[`VSD_PRIV_HI:`VSD_PRIV_LO];
      err_lvl_reg <= status_rst[`VSD_ERR_LVL_BIT];
      exc_lvl_reg <= status_rst[`VSD_EXC_LVL_BIT];
    end else begin
      if (sw_status) begin
        priv_reg <= wdata_reg[`VSD_PRIV_HI:`VSD_PRIV_LO];
        err_lvl_reg <= wdata_reg[`VSD_ERR_LVL_BIT];
        exc_lvl_reg <= wdata_reg[`VSD_EXC_LVL_BIT];
      end
      if (i_exc_take) begin
        exc_lvl_reg <= 1'b1;
      end else if (i_exc_return) begin
        if (err_lvl_reg) err_lvl_reg <= 1'b0;
        else exc_lvl_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      asid_reg <= 8'h00;
      seg0_attr_reg <= `VSD_SEG0_ATTR_RST;
    end else if (do_write && wstrb_reg[0]) begin
      if (awaddr_reg == `VSD_OFF_ENTRY_HI) asid_reg <= wdata_reg[7:0];
      if (awaddr_reg == `VSD_OFF_CONFIG) seg0_attr_reg <= wdata_reg[2:0];
    end
  end

  // read channel
  assign ar_take = i_s_axi_arvalid && o_s_axi_arready;
  assign rvalid_next = ar_take ? 1'b1 : (o_s_axi_rvalid && !i_s_axi_rready);
  always_comb begin
    rdata_next = 32'h00000000;
    rresp_next = `VSD_RESP_OKAY;
    unique case ({i_s_axi_araddr[11:2], 2'h0})
      `VSD_OFF_STATUS: rdata_next = {27'h0000000, priv_reg, err_lvl_reg, exc_lvl_reg, 1'b0};
      `VSD_OFF_ENTRY_HI: rdata_next = {24'h000000, asid_reg};
      `VSD_OFF_CONFIG: rdata_next = {29'h00000000, seg0_attr_reg};
      `VSD_OFF_MODE: rdata_next = {30'h00000000, dif.mode};
      `VSD_OFF_RESULT: rdata_next = {26'h0000000, o_addr_err, o_mapped, o_seg};
      default: rresp_next = `VSD_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_arready <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `VSD_RESP_OKAY;
    end else begin
      o_s_axi_rvalid <= rvalid_next;
      o_s_axi_arready <= !rvalid_next;
      if (ar_take) begin
        o_s_axi_rdata <= rdata_next;
        o_s_axi_rresp <= rresp_next;
      end
    end
  end

  // per-access classification, one cycle after the request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_mode <= 2'h0;
      o_seg <= 4'h0;
      o_mapped <= 1'b0;
      o_tag_append <= 1'b0;
      o_addr_err <= 1'b0;
      o_pa <= 48'h000000000000;
      o_attr <= 3'h0;
      o_cached <= 1'b0;
      va_reg <= 64'h0000000000000000;
    end else begin
      o_valid <= i_req;
      if (i_req) begin
        va_reg <= i_va;
        o_mode <= dif.mode;
        o_seg <= dif.seg;
        o_mapped <= dif.mapped;
        o_tag_append <= dif.mapped;
        o_addr_err <= dif.addr_err;
        o_pa <= dif.pa;
        o_attr <= dif.attr;
        o_cached <= dif.cached;
      end
    end
  end

  // tag, global bit, page split and refill vector
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_asid <= 8'h00;
      o_global <= 1'b0;
      o_page_offset <= 24'h000000;
      o_vpn <= 36'h000000000;
      o_refill_ext <= 1'b0;
      o_refill_offset <= 12'h000;
    end else begin
      o_asid <= asid_reg;
      o_global <= i_tlb_global;
      if (i_req) begin
        o_page_offset <= i_page_16m ? i_va[23:0] : {12'h000, i_va[11:0]};
        o_vpn <= i_page_16m ? {12'h000, i_va[47:24]} : i_va[47:12];
      end
      o_refill_ext <= i_tlb_miss && o_valid && o_seg == vsd_pkg::seg_user64;
      o_refill_offset <= `VSD_REFILL_OFF;
    end
  end

  sequence s_user_req;
    i_req && dif.mode == vsd_pkg::mode_user;
  endsequence
  sequence s_kern_req;
    i_req && dif.mode == vsd_pkg::mode_kern;
  endsequence
  sequence s_phys_req;
    s_kern_req ##0 i_va[63:62] == `VSD_TOP_PHYS;
  endsequence
  sequence s_sup_req;
    i_req && dif.mode == vsd_pkg::mode_sup;
  endsequence
  sequence s_compat_req;
    s_kern_req ##0 i_va[63:31] == 33'h1ffffffff;
  endsequence

  AST_MODE_DECODE: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req && !exc_lvl_reg && !err_lvl_reg && priv_reg == `VSD_PRIV_USER |=> o_mode == vsd_pkg::mode_user)
    else $error("user mode not reported");
  AST_EXC_ENTER: assert property (@(posedge i_clk) disable iff (i_rst)
    i_exc_take |=> dif.mode == vsd_pkg::mode_kern)
    else $error("exception did not enter kernel mode");
  AST_EXC_RETURN: assert property (@(posedge i_clk) disable iff (i_rst)
    i_exc_return && !i_exc_take && !sw_status && !err_lvl_reg |=> !exc_lvl_reg && priv_reg == $past(priv_reg))
    else $error("return did not restore mode");
  AST_USER_ERR: assert property (@(posedge i_clk) disable iff (i_rst)
    s_user_req ##0 i_va[63:48] != 16'h0000 |=> o_addr_err && !o_mapped)
    else $error("user high address not refused");
  AST_SUP_ERR: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req && dif.mode == vsd_pkg::mode_sup && i_va[63:62] == `VSD_TOP_PHYS |=> o_addr_err)
    else $error("supervisor address outside ranges accepted");
  AST_PHYS_PA: assert property (@(posedge i_clk) disable iff (i_rst)
    s_phys_req ##0 i_va[58:48] == 11'h000 |=> !o_mapped && o_pa == va_reg[47:0] && o_attr == va_reg[61:59])
    else $error("direct window address wrong");
  AST_PHYS_ERR: assert property (@(posedge i_clk) disable iff (i_rst)
    s_phys_req ##0 i_va[58:48] != 11'h000 |=> o_addr_err)
    else $error("direct window high bits not refused");
  AST_CACHED: assert property (@(posedge i_clk) disable iff (i_rst)
    o_valid && !o_mapped && !o_addr_err |-> o_cached == (o_attr == `VSD_C_CACHED))
    else $error("cache attribute misapplied");
  AST_COMPAT1: assert property (@(posedge i_clk) disable iff (i_rst)
    s_kern_req ##0 i_va[63:29] == 35'h7fffffffd |=> !o_mapped && !o_cached)
    else $error("second compat segment not uncached unmapped");
  AST_REFILL: assert property (@(posedge i_clk) disable iff (i_rst)
    o_valid && o_seg == vsd_pkg::seg_user64 && i_tlb_miss |=> o_refill_ext && o_refill_offset == `VSD_REFILL_OFF)
    else $error("extended refill not raised");
  AST_SUP_MODE: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req && !exc_lvl_reg && !err_lvl_reg && priv_reg == `VSD_PRIV_SUP |=> o_mode == vsd_pkg::mode_sup)
    else $error("supervisor mode not reported");
  AST_KERN_MODE: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req && (exc_lvl_reg || err_lvl_reg || priv_reg == `VSD_PRIV_KERN) |=> o_mode == vsd_pkg::mode_kern)
    else $error("kernel mode not reported");
  AST_SUP_USER: assert property (@(posedge i_clk) disable iff (i_rst)
    s_sup_req ##0 i_va[63:48] == 16'h0000 |=> o_seg == vsd_pkg::seg_sup_user && o_tag_append)
    else $error("supervisor user view not selected");
  AST_SUP_CUR: assert property (@(posedge i_clk) disable iff (i_rst)
    s_sup_req ##0 i_va[63:48] == 16'h4000 |=> o_seg == vsd_pkg::seg_sup_cur && o_tag_append)
    else $error("current supervisor segment not selected");
  AST_SUP_COMPAT: assert property (@(posedge i_clk) disable iff (i_rst)
    s_sup_req ##0 i_va[63:29] == 35'h7fffffffe |=> o_seg == vsd_pkg::seg_sup_compat && o_tag_append)
    else $error("supervisor compat segment not selected");
  AST_KERN_USER: assert property (@(posedge i_clk) disable iff (i_rst)
    s_kern_req ##0 i_va[63:48] == 16'h0000 |=> o_seg == vsd_pkg::seg_kern_user && o_tag_append)
    else $error("kernel user view not selected");
  AST_KERN_SUP: assert property (@(posedge i_clk) disable iff (i_rst)
    s_kern_req ##0 i_va[63:48] == 16'h4000 |=> o_seg == vsd_pkg::seg_kern_sup && o_tag_append)
    else $error("kernel supervisor view not selected");
  AST_KERN_MAPPED: assert property (@(posedge i_clk) disable iff (i_rst)
    s_kern_req ##0 i_va[63:62] == `VSD_TOP_HIGH && i_va[61:31] != 31'h7fffffff
    |=> o_seg == vsd_pkg::seg_kern_mapped && o_tag_append)
    else $error("kernel mapped segment not selected");
  AST_COMPAT3: assert property (@(posedge i_clk) disable iff (i_rst)
    s_compat_req ##0 i_va[30:29] == `VSD_CSEL_KERN |=> o_seg == vsd_pkg::seg_compat3 && o_mapped)
    else $error("fourth compat segment not selected");
  AST_COMPAT0: assert property (@(posedge i_clk) disable iff (i_rst)
    s_compat_req ##0 i_va[30:29] == `VSD_CSEL_SEG0 |=> !o_mapped && o_attr == $past(seg0_attr_reg))
    else $error("first compat segment attribute wrong");
  AST_TAG_GLOBAL: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req |=> o_asid == $past(asid_reg) && o_global == $past(i_tlb_global))
    else $error("tag or global bit wrong");
  AST_PAGE_4K: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req && !i_page_16m |=> o_page_offset == {12'h000, va_reg[11:0]} && o_vpn == va_reg[47:12])
    else $error("small page split wrong");
  AST_PAGE_16M: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req && i_page_16m |=> o_page_offset == va_reg[23:0] && o_vpn == {12'h000, va_reg[47:24]})
    else $error("large page split wrong");
endmodule

// ---- verification/vsd_pipe_model.sv ----
// pipeline side model: tlb miss report and matched-entry global bit
// assumes it shares the core clock and reset with vsd_top
`timescale 1ns/1ps
module vsd_pipe_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_miss_en,
  input wire logic i_valid,
  output logic o_tlb_miss,
  output logic o_tlb_global
);
  // miss answered in the cycle the result is valid
  assign o_tlb_miss = i_miss_en & i_valid;
  // global bit changes every cycle so a stale copy shows
  always @(posedge i_clk) begin
    o_tlb_global <= i_rst ? 1'b0 : ~o_tlb_global;
  end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the segment decoder
// assumes vsd_top, vsd_pipe_model and a 250 mhz core clock
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, req = 0, p16 = 0, xt = 0, xr = 0, men = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rv32;
  logic [3:0] ws = 0, sg;
  logic [63:0] va = 0;
  logic awrdy, wrdy, bv, arrdy, rv, vld, mpd, tag, aerr, cch, glbo, rext, miss, glb;
  logic [1:0] br, rr, md;
  logic [47:0] pa;
  logic [2:0] at;
  logic [7:0] asid;
  logic [23:0] po;
  logic [35:0] vpn;
  logic [11:0] roff;
  int mismatches = 0, checks_done = 0;
  int priv = 0, exception_level_bit = 0, error_level_bit = 0, cfg = 2, tagv = 0;
  logic [63:0] tbl [16] = '{64'h0, 64'h0000_ffff_ffff_ffff, 64'h0001_0000_0000_0000, 64'h4000_ffff_ffff_f123,
    64'h4001_0000_0000_0000, 64'h8000_1234_5678_9abc, 64'h9800_ffff_0000_1000, 64'h8001_0000_0000_0000,
    64'hc000_0000_0000_0000, 64'hffff_ffff_8000_0010, 64'hffff_ffff_a000_0020, 64'hffff_ffff_c000_0030,
    64'hffff_ffff_e000_0040, 64'hffff_ffff_dfff_ffff, 64'hffff_ffff_7fff_ffff, 64'h3fff_0000_0000_0000};

  always #2 clk = ~clk;

  vsd_top u_dut (.i_clk(clk), .i_rst(rst), .i_s_axi_awvalid(awv), .o_s_axi_awready(awrdy),
    .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arrdy), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv),
    .i_s_axi_rready(rry), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .i_req(req), .i_va(va),
    .i_page_16m(p16), .i_exc_take(xt), .i_exc_return(xr), .i_tlb_miss(miss), .i_tlb_global(glb),
    .o_valid(vld), .o_mode(md), .o_seg(sg), .o_mapped(mpd), .o_tag_append(tag), .o_addr_err(aerr),
    .o_pa(pa), .o_attr(at), .o_cached(cch), .o_asid(asid), .o_global(glbo), .o_page_offset(po),
    .o_vpn(vpn), .o_refill_ext(rext), .o_refill_offset(roff));

  vsd_pipe_model u_pipe (.i_clk(clk), .i_rst(rst), .i_miss_en(men), .i_valid(vld),
    .o_tlb_miss(miss), .o_tlb_global(glb));

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic int mexp();
    return (exception_level_bit || error_level_bit || priv == 0) ? 0 : (priv == 1 ? 1 : 2);
  endfunction

  // reference classification of one address in the current mode
  function automatic void mdl(input logic [63:0] v, output int s, output int mp, output logic [47:0] p,
    output int a);
    s = 0;
    mp = 0;
    p = 0;
    a = 2;
    case (mexp())
      2: if (v[63:48] == 0) begin s = 1; mp = 1; end
      1: begin
        if (v[63:48] == 0) begin s = 2; mp = 1; end
        else if (v[63:48] == 16'h4000) begin s = 3; mp = 1; end
        else if (v[63:29] == 35'h7fffffffe) begin s = 4; mp = 1; end
      end
      default: case (v[63:62])
        2'h0: if (v[61:48] == 0) begin s = 5; mp = 1; end
        2'h1: if (v[61:48] == 0) begin s = 6; mp = 1; end
        2'h2: begin p = v[47:0]; a = v[61:59]; if (v[58:48] == 0) s = 7; end
        default: begin
          if (&v[61:31]) begin
            s = 9 + v[30:29];
            mp = s > 10;
            p = v[28:0];
            if (s == 9) a = cfg;
          end else begin
            s = 8;
            mp = 1;
          end
        end
      endcase
    endcase
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit qa, qw;
    @(posedge clk);
    awv <= 1; awa <= a; wv <= 1; wd <= d; ws <= 4'hf; bry <= 1;
    qa = 1;
    qw = 1;
    while (qa || qw) begin
      @(posedge clk);
      if (qa && awrdy) begin qa = 0; awv <= 0; end
      if (qw && wrdy) begin qw = 0; wv <= 0; end
    end
    while (bv !== 1'b1) @(posedge clk);
    bry <= 0;
    chk("bresp", br, er);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    arv <= 1; ara <= a; rry <= 1;
    do @(posedge clk); while (arrdy !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    rv32 = rdat;
    rry <= 0;
    chk("rresp", rr, er);
    chk("rdata", rv32, exp);
  endtask

  task automatic stat(input int d);
    wr(12'h000, d, 2'h0);
    priv = d[4:3];
    error_level_bit = d[2];
    exception_level_bit = d[1];
  endtask

  task automatic pulse(input bit take);
    @(posedge clk);
    if (take) xt <= 1;
    else xr <= 1;
    @(posedge clk);
    xt <= 0;
    xr <= 0;
  endtask

  task automatic acc(input logic [63:0] v);
    int s, mp, a;
    logic [47:0] p;
    logic g, h;
    mdl(v, s, mp, p, a);
    h = 1'($urandom);
    @(posedge clk);
    req <= 1; va <= v; p16 <= h;
    #1 g = glb;
    @(posedge clk);
    req <= 0;
    #1 chk("valid", vld, 1);
    chk("mode", md, mexp());
    chk("seg", sg, s);
    chk("mapped", mpd, mp);
    chk("tag", tag, mp);
    chk("err", aerr, s == 0);
    chk("pa", pa, p);
    if (!mp && s != 0) chk("attr", at, a);
    chk("cached", cch, !mp && s != 0 && a == 3);
    chk("asid", asid, tagv);
    chk("global", glbo, g);
    chk("vpn", vpn, h ? v[47:24] : v[47:12]);
    chk("offset", po, h ? v[23:0] : v[11:0]);
    @(posedge clk);
    #1 chk("refill", rext, men && s == 1);
  endtask

  task automatic run_all();
    for (int i = 0; i < 16; i++) acc(tbl[i]);
    repeat (6) acc({$urandom, $urandom});
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    void'($urandom(42));
    repeat (5) @(posedge clk);
    rst <= 0;
    rdchk(12'h000, 0, 2'h0);
    rdchk(12'h004, 0, 2'h0);
    rdchk(12'h008, 2, 2'h0);
    rdchk(12'h020, 0, 2'h2);
    wr(12'h020, 32'h1f, 2'h2);
    chk("refill_offset", roff, 12'h080);
    for (int i = 0; i < 16; i++) begin
      stat(i << 1);
      rdchk(12'h00c, mexp(), 2'h0);
    end
    foreach (tbl[k]) begin
      if (k < 3) begin
        stat(k * 8);
        tagv = $urandom % 256;
        wr(12'h004, tagv, 2'h0);
        cfg = (k == 0) ? 3 : $urandom % 8;
        wr(12'h008, cfg, 2'h0);
        men <= (k == 2);
        run_all();
      end
    end
    pulse(1);
    exception_level_bit = 1;
    rdchk(12'h00c, 0, 2'h0);
    men <= 0;
    run_all();
    pulse(0);
    exception_level_bit = 0;
    rdchk(12'h00c, 2, 2'h0);
    stat(32'h14);
    rdchk(12'h00c, 0, 2'h0);
    pulse(0);
    error_level_bit = 0;
    rdchk(12'h00c, 2, 2'h0);
    wrap_up();
  end
endmodule
